// *** include/socfg_pkg.sv ***
// shared constants and carrier types for the supply output configuration block
// assumes one 50 MHz clock and an active-low asynchronous reset
package socfg_pkg;

   localparam int unsigned CLK_MHZ = 50;

   // register offsets
   localparam logic [7:0] OFS_MODE_A  = 8'h1f;
   localparam logic [7:0] OFS_MODE_B  = 8'h20;
   localparam logic [7:0] OFS_MODE_C  = 8'h21;
   localparam logic [7:0] OFS_MODE_D  = 8'h22;
   localparam logic [7:0] OFS_PINFUNC = 8'h23;
   localparam logic [7:0] OFS_TMO     = 8'h19;
   localparam logic [7:0] OFS_WD_LO   = 8'h1d;
   localparam logic [7:0] OFS_WD_HI   = 8'h1e;
   localparam logic [7:0] OFS_SWCTL   = 8'h4d;

   // field positions
   localparam int unsigned SOFT_OVR_BIT   = 1;
   localparam int unsigned TMO_LSB        = 4;
   localparam int unsigned EXPIRY_SEL_BIT = 7;
   localparam int unsigned KICK_LSB       = 4;
   localparam int unsigned PINF_OVR_BIT   = 0;
   localparam int unsigned PINF_MAN_BIT   = 1;

   // reset values
   localparam logic [7:0] MODE_RST    = 8'h00;
   localparam logic [7:0] CFG_RST     = 8'h00;
   localparam logic [1:0] PINFUNC_RST = 2'h0;

   // selection codes
   localparam logic [2:0] EXPIRY_CODE = 3'h6;
   localparam logic [2:0] KICK_CODE   = 3'h7;

   // output drive modes
   localparam logic [2:0] MODE_OD_LO  = 3'h0;
   localparam logic [2:0] MODE_OD_HI  = 3'h1;
   localparam logic [2:0] MODE_PP_LO  = 3'h2;
   localparam logic [2:0] MODE_PP_HI  = 3'h3;
   localparam logic [2:0] MODE_TRACK  = 3'h4;
   localparam logic [2:0] MODE_PUMP   = 3'h5;

   // reset timeout periods in microseconds, one per selector value
   localparam int unsigned TMO_US [8] = '{25, 1500, 2500, 5000, 10000, 20000, 40000, 80000};

   typedef struct packed {
      logic alarm_1;
      logic alarm_2;
      logic any_alarm;
      logic reset_out;
   } socfg_mon_s;

   typedef struct packed {
      logic [11:0] pin_o;
      logic [11:0] pin_oe;
      logic [3:0]  track;
      logic [5:0]  pump;
   } socfg_drv_s;

   typedef struct packed {
      logic [31:0] cnt;
      logic        busy;
   } socfg_tmr_s;

   typedef struct packed {
      logic [7:0] mode_a;
      logic [7:0] mode_b;
      logic [7:0] mode_c;
      logic [5:0] mode_d;
      logic [1:0] pinfunc;
      logic [2:0] tmo_sel;
      logic [7:0] wd_lo;
      logic [1:0] wd_hi;
      logic       soft_ovr;
      logic [7:0] rdata;
      socfg_mon_s held;
      logic       guard;
      logic       viol;
      logic       flog;
      logic       kick;
      logic       expiry_oe;
      logic       man_prev;
   } socfg_top_s;

endpackage

// *** src/socfg_rst_timer.sv ***
// reset timeout counter: busy from a start pulse for the loaded period
// assumes the period is at least one cycle
`timescale 1ns/1ps
module socfg_rst_timer
   import socfg_pkg::*;
(
   input  wire logic        i_clock,
   input  wire logic        i_rst_b,
   input  wire logic        i_start,
   input  wire logic [31:0] i_period,
   output logic             o_busy
);

   socfg_tmr_s st_q;
   socfg_tmr_s st_d;

   always_comb begin
      st_d = st_q;
      if (i_start) begin
         st_d.cnt = i_period;
      end else if (st_q.cnt != 32'h0) begin
         st_d.cnt = st_q.cnt - 32'h1;
      end
      st_d.busy = (st_d.cnt != 32'h0);
   end

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign o_busy = st_q.busy;

endmodule

// *** src/socfg_rail_drv.sv ***
// pin drive decode for the twelve rail switch outputs
// assumes mode codes already assembled to three bits per output
`timescale 1ns/1ps
module socfg_rail_drv
   import socfg_pkg::*;
(
   input  wire logic              i_clock,
   input  wire logic              i_rst_b,
   input  wire logic [11:0][2:0]  i_mode,
   input  wire logic [11:0]       i_on,
   output socfg_drv_s             o_drv
);

   socfg_drv_s st_q;
   socfg_drv_s st_d;

   // returns {o, oe, track, pump}; reserved codes release the pin
   function automatic logic [3:0] drive(input logic [2:0] mode, input logic on,
                                        input logic track_ok);
      case (mode)
         MODE_OD_LO: drive = {1'b0, on, 2'b00};
         MODE_OD_HI: drive = {1'b0, ~on, 2'b00};
         MODE_PP_LO: drive = {~on, 1'b1, 2'b00};
         MODE_PP_HI: drive = {on, 1'b1, 2'b00};
         MODE_TRACK: drive = {2'b00, on & track_ok, 1'b0};
         MODE_PUMP:  drive = {3'b000, on};
         default:    drive = 4'h0;
      endcase
   endfunction

   always_comb begin
      logic [3:0] d;
      d = 4'h0;
      st_d = '0;
      for (int i = 0; i < 12; i++) begin
         d = drive(i_mode[i], i_on[i], (i < 4));
         st_d.pin_o[i] = d[3];
         st_d.pin_oe[i] = d[2];
         if (i < 4) begin
            st_d.track[i] = d[1];
         end
         if (i < 6) begin
            st_d.pump[i] = d[0];
         end
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign o_drv = st_q;

endmodule

// *** src/socfg_top.sv ***
// output drive configuration and multipurpose pin functions
// assumes pins synchronous to i_clock; monitor results arrive as live levels
// Operation
// - pin 6 may act as an active-low guardband override input.
// - guardband enabled when override input low or soft override bit set.
// - while guardband enabled, alarm and reset outputs hold their values.
// - while guardband enabled, violations ignored and no fault logged.
// - pin 4 may act as active-low manual reset; low asserts reset.
// - after manual reset release, reset held for the timeout period.
// - pin 6 becomes watchdog expiry output when selection code is 110.
// - pin 5 becomes watchdog kick input when selection field is 111.
// - watchdog expiry output is open-drain, active low.
// - outputs 1-6 three-bit codes select open-drain or push-pull, either polarity.
// - outputs 1-4 code 100 selects closed-loop tracking.
// - outputs 1-6 code 101 selects charge-pump drive.
// - codes 110, 111 reserved; 100 reserved for outputs 5 and 6.
// - first byte holds outputs 1, 2 and low bits of output 3.
// - second byte holds output 3 top bit, outputs 4, 5, output 6 low bit.
// - outputs 7-12 two-bit codes select drive type and polarity.
// - third and fourth bytes hold outputs 7-12; top two bits reserved.
// - timeout period comes from the three-bit timeout selector.
`timescale 1ns/1ps
module socfg_top
   import socfg_pkg::*;
#(
   parameter int unsigned P_CYCLES_PER_US = CLK_MHZ
)
(
   input  wire logic        i_clock,
   input  wire logic        i_rst_b,
   input  wire logic        i_reg_wr,
   input  wire logic [7:0]  i_reg_addr,
   input  wire logic [7:0]  i_reg_wdata,
   output logic      [7:0]  o_reg_rdata,
   input  wire logic        i_multi_pin_4,
   input  wire logic        i_multi_pin_5,
   input  wire logic        i_multi_pin_6,
   input  wire socfg_mon_s  i_live,
   input  wire logic        i_threshold_viol,
   input  wire logic        i_fault_log_req,
   input  wire logic        i_wdog_expired,
   input  wire logic [11:0] i_rail_on,
   output socfg_mon_s       o_mon,
   output logic             o_guard_active,
   output logic             o_viol_accept,
   output logic             o_fault_log_we,
   output logic             o_watchdog_kick_in,
   output logic             o_multi_pin_6_o,
   output logic             o_multi_pin_6_oe,
   output logic [11:0]      o_rail_switch_out_o,
   output logic [11:0]      o_rail_switch_out_oe,
   output logic [3:0]       o_rail_track,
   output logic [5:0]       o_rail_pump
);

   socfg_top_s       st_q;
   socfg_top_s       st_d;
   logic [11:0][2:0] mode;
   logic             expiry_sel;
   logic             kick_sel;
   logic             ovr_pin_en;
   logic             man_en;
   logic             guard_now;
   logic             man_low;
   logic             man_rise;
   logic             tmo_busy;
   logic [31:0]      tmo_period;
   socfg_drv_s       drv;

   function automatic logic [31:0] tmo_cycles(input logic [2:0] sel);
      tmo_cycles = 32'(TMO_US[sel] * P_CYCLES_PER_US);
   endfunction

   // mode fields as packed into the four configuration bytes
   always_comb begin
      mode[0]  = st_q.mode_a[2:0];
      mode[1]  = st_q.mode_a[5:3];
      mode[2]  = {st_q.mode_b[0], st_q.mode_a[7:6]};
      mode[3]  = st_q.mode_b[3:1];
      mode[4]  = st_q.mode_b[6:4];
      mode[5]  = {st_q.mode_c[1:0], st_q.mode_b[7]};
      mode[6]  = {1'b0, st_q.mode_c[3:2]};
      mode[7]  = {1'b0, st_q.mode_c[5:4]};
      mode[8]  = {1'b0, st_q.mode_c[7:6]};
      mode[9]  = {1'b0, st_q.mode_d[1:0]};
      mode[10] = {1'b0, st_q.mode_d[3:2]};
      mode[11] = {1'b0, st_q.mode_d[5:4]};
   end

   // pin function selection
   assign expiry_sel = ({st_q.wd_hi, st_q.wd_lo[EXPIRY_SEL_BIT]} == EXPIRY_CODE);
   assign kick_sel   = (st_q.wd_lo[KICK_LSB +: 3] == KICK_CODE);
   assign ovr_pin_en = st_q.pinfunc[PINF_OVR_BIT] & ~expiry_sel;
   assign man_en     = st_q.pinfunc[PINF_MAN_BIT];
   assign guard_now  = (ovr_pin_en & ~i_multi_pin_6) | st_q.soft_ovr;
   assign man_low    = man_en & ~i_multi_pin_4;
   assign man_rise   = man_en & i_multi_pin_4 & ~st_q.man_prev;
   assign tmo_period = tmo_cycles(st_q.tmo_sel);

   always_comb begin
      st_d = st_q;
      if (i_reg_wr) begin
         case (i_reg_addr)
            OFS_MODE_A:  st_d.mode_a = i_reg_wdata;
            OFS_MODE_B:  st_d.mode_b = i_reg_wdata;
            OFS_MODE_C:  st_d.mode_c = i_reg_wdata;
            OFS_MODE_D:  st_d.mode_d = i_reg_wdata[5:0];
            OFS_PINFUNC: st_d.pinfunc = i_reg_wdata[1:0];
            OFS_TMO:     st_d.tmo_sel = i_reg_wdata[TMO_LSB +: 3];
            OFS_WD_LO:   st_d.wd_lo = i_reg_wdata;
            OFS_WD_HI:   st_d.wd_hi = i_reg_wdata[1:0];
            OFS_SWCTL:   st_d.soft_ovr = i_reg_wdata[SOFT_OVR_BIT];
            default:     st_d.soft_ovr = st_q.soft_ovr;
         endcase
      end
      case (i_reg_addr)
         OFS_MODE_A:  st_d.rdata = st_q.mode_a;
         OFS_MODE_B:  st_d.rdata = st_q.mode_b;
         OFS_MODE_C:  st_d.rdata = st_q.mode_c;
         OFS_MODE_D:  st_d.rdata = {2'b00, st_q.mode_d};
         OFS_PINFUNC: st_d.rdata = {6'h00, st_q.pinfunc};
         OFS_TMO:     st_d.rdata = {1'b0, st_q.tmo_sel, 4'h0};
         OFS_WD_LO:   st_d.rdata = st_q.wd_lo;
         OFS_WD_HI:   st_d.rdata = {6'h00, st_q.wd_hi};
         OFS_SWCTL:   st_d.rdata = {6'h00, st_q.soft_ovr, 1'b0};
         default:     st_d.rdata = 8'h00;
      endcase
      st_d.man_prev = man_en ? i_multi_pin_4 : 1'b1;
      st_d.guard = guard_now;
      if (!guard_now) begin
         // live results pass once the guardband is off
         st_d.held.alarm_1 = i_live.alarm_1;
         st_d.held.alarm_2 = i_live.alarm_2;
         st_d.held.any_alarm = i_live.any_alarm;
         st_d.held.reset_out = i_live.reset_out | man_low | man_rise | tmo_busy;
      end
      st_d.viol = i_threshold_viol & ~guard_now;
      st_d.flog = i_fault_log_req & ~guard_now;
      st_d.kick = kick_sel & i_multi_pin_5;
      st_d.expiry_oe = expiry_sel & i_wdog_expired;
   end

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st_q <= '{mode_a: MODE_RST, mode_b: MODE_RST, mode_c: MODE_RST,
                   mode_d: MODE_RST[5:0], pinfunc: PINFUNC_RST,
                   tmo_sel: CFG_RST[2:0], wd_lo: CFG_RST, wd_hi: CFG_RST[1:0],
                   soft_ovr: 1'b0, rdata: 8'h00, held: '0, guard: 1'b0,
                   viol: 1'b0, flog: 1'b0, kick: 1'b0, expiry_oe: 1'b0,
                   man_prev: 1'b1};
      end else begin
         st_q <= st_d;
      end
   end

   socfg_rst_timer u_tmr (
      .i_clock  (i_clock),
      .i_rst_b  (i_rst_b),
      .i_start  (man_rise),
      .i_period (tmo_period),
      .o_busy   (tmo_busy)
   );

   socfg_rail_drv u_drv (
      .i_clock (i_clock),
      .i_rst_b (i_rst_b),
      .i_mode  (mode),
      .i_on    (i_rail_on),
      .o_drv   (drv)
   );

   assign o_reg_rdata          = st_q.rdata;
   assign o_mon                = st_q.held;
   assign o_guard_active       = st_q.guard;
   assign o_viol_accept        = st_q.viol;
   assign o_fault_log_we       = st_q.flog;
   assign o_watchdog_kick_in   = st_q.kick;
   assign o_multi_pin_6_o      = 1'b0;
   assign o_multi_pin_6_oe     = st_q.expiry_oe;
   assign o_rail_switch_out_o  = drv.pin_o;
   assign o_rail_switch_out_oe = drv.pin_oe;
   assign o_rail_track         = drv.track;
   assign o_rail_pump          = drv.pump;

   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_rst_b);

   guard_source_a: assert property (
      ((st_q.pinfunc[PINF_OVR_BIT] && !expiry_sel && !i_multi_pin_6) || st_q.soft_ovr)
      |=> o_guard_active)
      else $error("guardband not entered");

   guard_freeze_a: assert property (
      guard_now |=> $stable(o_mon))
      else $error("held outputs moved under guardband");

   guard_block_a: assert property (
      guard_now |=> !o_viol_accept && !o_fault_log_we)
      else $error("violation passed under guardband");

   guard_release_a: assert property (
      !guard_now |=> o_mon.alarm_1 == $past(i_live.alarm_1)
                     && o_mon.any_alarm == $past(i_live.any_alarm))
      else $error("alarms not following live values");

   manual_reset_a: assert property (
      man_low |=> o_mon.reset_out || $past(guard_now))
      else $error("manual reset did not assert reset");

   man_timeout_a: assert property (
      (man_rise && !guard_now) ##1 !guard_now |=> o_mon.reset_out)
      else $error("reset released at manual reset release");

   expiry_drive_a: assert property (
      expiry_sel && i_wdog_expired |=> o_multi_pin_6_oe && !o_multi_pin_6_o)
      else $error("expiry output not pulled low");

   kick_gate_a: assert property (
      !kick_sel |=> !o_watchdog_kick_in)
      else $error("kick seen while pin 5 not selected");

   pp_low_a: assert property (
      st_q.mode_a[2:0] == MODE_PP_LO && !i_reg_wr |=>
      o_rail_switch_out_oe[0] && o_rail_switch_out_o[0] == !$past(i_rail_on[0]))
      else $error("output 1 push-pull low drive wrong");

   track_sel_a: assert property (
      st_q.mode_b[3:1] == MODE_TRACK && !i_reg_wr |=>
      o_rail_track[3] == $past(i_rail_on[3]) && !o_rail_switch_out_oe[3])
      else $error("output 4 tracking wrong");

   pump_sel_a: assert property (
      {st_q.mode_c[1:0], st_q.mode_b[7]} == MODE_PUMP && !i_reg_wr |=>
      o_rail_pump[5] == $past(i_rail_on[5]))
      else $error("output 6 charge pump wrong");

   reserved_a: assert property (
      st_q.mode_b[6:4] == MODE_TRACK && !i_reg_wr |=>
      !o_rail_pump[4] && !o_rail_switch_out_oe[4])
      else $error("output 5 reserved code drives pin");

   two_bit_a: assert property (
      st_q.mode_c[3:2] == MODE_PP_HI[1:0] && !i_reg_wr |=>
      o_rail_switch_out_oe[6] && o_rail_switch_out_o[6] == $past(i_rail_on[6]))
      else $error("output 7 push-pull high drive wrong");

   viol_pass_a: assert property (
      !guard_now |=>
      o_viol_accept == $past(i_threshold_viol))
      else $error("violation lost outside guardband");

   log_pass_a: assert property (
      !guard_now |=>
      o_fault_log_we == $past(i_fault_log_req))
      else $error("fault log request lost outside guardband");

   guard_clear_a: assert property (
      !(st_q.pinfunc[PINF_OVR_BIT] && !expiry_sel && !i_multi_pin_6)
      && !st_q.soft_ovr |=> !o_guard_active)
      else $error("guardband active without a cause");

   expiry_guard_a: assert property (
      expiry_sel && !st_q.soft_ovr |=>
      !o_guard_active)
      else $error("pin 6 override active while expiry output selected");

   alarm2_follow_a: assert property (
      !guard_now |=>
      o_mon.alarm_2 == $past(i_live.alarm_2))
      else $error("alarm 2 not following live value");

   reset_follow_a: assert property (
      !guard_now && !man_en && !tmo_busy |=>
      o_mon.reset_out == $past(i_live.reset_out))
      else $error("reset output not following live value");

   man_release_a: assert property (
      man_en && i_multi_pin_4 && st_q.man_prev && !tmo_busy && !guard_now
      && !i_live.reset_out |=> !o_mon.reset_out)
      else $error("reset held after timeout ended");

   timer_hold_a: assert property (
      man_rise |=>
      tmo_busy [*8])
      else $error("reset timeout ended too soon");

   kick_route_a: assert property (
      kick_sel |=>
      o_watchdog_kick_in == $past(i_multi_pin_5))
      else $error("kick not passed from pin 5");

   expiry_idle_a: assert property (
      !(expiry_sel && i_wdog_expired) |=>
      !o_multi_pin_6_oe)
      else $error("pin 6 pulled low without expiry");

   od_low_a: assert property (
      st_q.mode_a[5:3] == MODE_OD_LO |=>
      o_rail_switch_out_oe[1] == $past(i_rail_on[1]) && !o_rail_switch_out_o[1])
      else $error("output 2 open-drain low drive wrong");

   od_high_a: assert property (
      {st_q.mode_b[0], st_q.mode_a[7:6]} == MODE_OD_HI |=>
      o_rail_switch_out_oe[2] == !$past(i_rail_on[2]) && !o_rail_switch_out_o[2])
      else $error("output 3 open-drain high drive wrong");

   pp_high_a: assert property (
      st_q.mode_b[6:4] == MODE_PP_HI |=>
      o_rail_switch_out_oe[4] && o_rail_switch_out_o[4] == $past(i_rail_on[4]))
      else $error("output 5 push-pull high drive wrong");

   track_one_a: assert property (
      st_q.mode_a[2:0] == MODE_TRACK |=>
      o_rail_track[0] == $past(i_rail_on[0]) && !o_rail_switch_out_oe[0])
      else $error("output 1 tracking wrong");

   pump_four_a: assert property (
      st_q.mode_b[3:1] == MODE_PUMP |=>
      o_rail_pump[3] == $past(i_rail_on[3]) && !o_rail_switch_out_oe[3])
      else $error("output 4 charge pump wrong");

   reserved_six_a: assert property (
      {st_q.mode_c[1:0], st_q.mode_b[7]} == MODE_TRACK |=>
      !o_rail_pump[5] && !o_rail_switch_out_oe[5])
      else $error("output 6 reserved code drives pin");

   reserved_top_a: assert property (
      st_q.mode_a[2:1] == 2'h3 |=>
      !o_rail_switch_out_oe[0] && !o_rail_track[0] && !o_rail_pump[0])
      else $error("output 1 reserved code drives pin");

   two_bit_low_a: assert property (
      st_q.mode_d[1:0] == MODE_PP_LO[1:0] |=>
      o_rail_switch_out_oe[9] && o_rail_switch_out_o[9] == !$past(i_rail_on[9]))
      else $error("output 10 push-pull low drive wrong");

   two_bit_od_a: assert property (
      st_q.mode_d[5:4] == MODE_OD_HI[1:0] |=>
      o_rail_switch_out_oe[11] == !$past(i_rail_on[11]) && !o_rail_switch_out_o[11])
      else $error("output 12 open-drain high drive wrong");

   guard_cycle_c: cover property (guard_now ##1 guard_now ##1 !guard_now);
   man_release_c: cover property (man_low ##1 man_rise ##1 tmo_busy);
   expiry_fire_c: cover property (expiry_sel && i_wdog_expired);
   pump_on_c: cover property (|o_rail_pump);
   kick_seen_c: cover property (kick_sel && i_multi_pin_5);

endmodule

// *** tb/socfg_rail_load.sv ***
// far-side model of the twelve rail switch pins: supply enables with pull-ups
// assumes open-drain pins float high when the block releases them
`timescale 1ns/1ps
module socfg_rail_load
   import socfg_pkg::*;
(
   input  wire logic [11:0] i_pin_o,
   input  wire logic [11:0] i_pin_oe,
   output logic      [11:0] o_level
);
   // released pin is pulled up, driven pin shows the drive level
   always_comb begin
      for (int i = 0; i < 12; i++) begin
         o_level[i] = i_pin_oe[i] ? i_pin_o[i] : 1'b1;
      end
   end
endmodule

// *** tb/supply_output_config_and_pin_functions_tb.sv ***
// self-checking bench for the supply output configuration block
// assumes socfg_pkg compiled first; timeout scaled by P_CYCLES_PER_US = 1
`timescale 1ns/1ps
module supply_output_config_and_pin_functions_tb
   import socfg_pkg::*;
;
   logic        i_clock, i_rst_b, i_reg_wr, i_multi_pin_4, i_multi_pin_5, i_multi_pin_6;
   logic [7:0]  i_reg_addr, i_reg_wdata, o_reg_rdata;
   socfg_mon_s  i_live, o_mon;
   logic        i_threshold_viol, i_fault_log_req, i_wdog_expired;
   logic [11:0] i_rail_on, rail_o, rail_oe, rail_level;
   logic        guard, viol_acc, log_we, kick, p6_o, p6_oe;
   logic [3:0]  track;
   logic [5:0]  pump;
   int          miscompares, samples_checked, cycles, n;
   logic [7:0]  ra, rb, rc;

   socfg_top #(.P_CYCLES_PER_US(1)) dut (
      .i_clock(i_clock), .i_rst_b(i_rst_b), .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr),
      .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .i_multi_pin_4(i_multi_pin_4),
      .i_multi_pin_5(i_multi_pin_5), .i_multi_pin_6(i_multi_pin_6), .i_live(i_live),
      .i_threshold_viol(i_threshold_viol), .i_fault_log_req(i_fault_log_req),
      .i_wdog_expired(i_wdog_expired), .i_rail_on(i_rail_on), .o_mon(o_mon),
      .o_guard_active(guard), .o_viol_accept(viol_acc), .o_fault_log_we(log_we),
      .o_watchdog_kick_in(kick), .o_multi_pin_6_o(p6_o), .o_multi_pin_6_oe(p6_oe),
      .o_rail_switch_out_o(rail_o), .o_rail_switch_out_oe(rail_oe),
      .o_rail_track(track), .o_rail_pump(pump));

   socfg_rail_load load (.i_pin_o(rail_o), .i_pin_oe(rail_oe), .o_level(rail_level));

   initial begin
      i_clock = 1'b0;
      forever #10 i_clock = ~i_clock;
   end

   task automatic end_of_test();
      if (miscompares == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         end_of_test();
      end
   end

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] dat);
      @(posedge i_clock);
      i_reg_wr    <= 1'b1;
      i_reg_addr  <= a;
      i_reg_wdata <= dat;
      @(posedge i_clock);
      i_reg_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge i_clock);
      i_reg_addr <= a;
      repeat (2) @(posedge i_clock);
      #1;
      chk("reg_rdata", {24'h0, exp}, {24'h0, o_reg_rdata});
   endtask

   task automatic settle();
      repeat (3) @(posedge i_clock);
      #1;
   endtask

   // expected {oe, o, track, pump} of one rail for its assembled code
   function automatic logic [3:0] rail_exp(input int idx, input logic [2:0] m, input logic on);
      case (m)
         3'h0: rail_exp = {on, 3'b000};
         3'h1: rail_exp = {!on, 3'b000};
         3'h2: rail_exp = {1'b1, !on, 2'b00};
         3'h3: rail_exp = {1'b1, on, 2'b00};
         3'h4: rail_exp = (idx < 4) ? {2'b00, on, 1'b0} : 4'h0;
         3'h5: rail_exp = (idx < 6) ? {3'b000, on} : 4'h0;
         default: rail_exp = 4'h0;
      endcase
   endfunction

   task automatic check_rails(input logic [7:0] a, b, c, d, input logic [11:0] on);
      logic [11:0][2:0] m;
      logic [11:0] eoe, eo, lvl;
      logic [3:0]  etr, r;
      logic [5:0]  epu;
      m = {{1'b0, d[5:4]}, {1'b0, d[3:2]}, {1'b0, d[1:0]}, {1'b0, c[7:6]}, {1'b0, c[5:4]},
           {1'b0, c[3:2]}, {c[1:0], b[7]}, b[6:4], b[3:1], {b[0], a[7:6]}, a[5:3], a[2:0]};
      etr = 4'h0;
      epu = 6'h0;
      for (int i = 0; i < 12; i++) begin
         r = rail_exp(i, m[i], on[i]);
         eoe[i] = r[3];
         eo[i] = r[2];
         if (i < 4) etr[i] = r[1];
         if (i < 6) epu[i] = r[0];
         lvl[i] = (m[i] < 3'h4) ? (m[i][0] ? on[i] : !on[i]) : 1'b1;
      end
      wr(OFS_MODE_A, a);
      wr(OFS_MODE_B, b);
      wr(OFS_MODE_C, c);
      wr(OFS_MODE_D, d);
      @(posedge i_clock);
      i_rail_on <= on;
      settle();
      chk("rail_oe", {20'h0, eoe}, {20'h0, rail_oe});
      chk("rail_o", {20'h0, eo & eoe}, {20'h0, rail_o & rail_oe});
      chk("rail_track", {28'h0, etr}, {28'h0, track});
      chk("rail_pump", {26'h0, epu}, {26'h0, pump});
      chk("rail_level", {20'h0, lvl}, {20'h0, rail_level});
      rd(OFS_MODE_D, {2'b00, d[5:0]});
   endtask

   initial begin
      miscompares = 0;
      samples_checked = 0;
      cycles = 0;
      i_rst_b = 1'b0;
      i_reg_wr = 1'b0;
      i_reg_addr = 8'h00;
      i_reg_wdata = 8'h00;
      i_multi_pin_4 = 1'b1;
      i_multi_pin_5 = 1'b0;
      i_multi_pin_6 = 1'b1; // override held high in normal running
      i_live = '0;
      i_threshold_viol = 1'b0;
      i_fault_log_req = 1'b0;
      i_wdog_expired = 1'b0;
      i_rail_on = 12'h000;
      void'($urandom(32'hb20a1800));
      repeat (20) @(posedge i_clock);
      i_rst_b <= 1'b1;
      rd(OFS_MODE_A, MODE_RST);
      rd(OFS_MODE_C, MODE_RST);
      wr(8'h7e, 8'hff);
      rd(8'h7e, 8'h00);
      // every code on every field, then random bytes
      for (int k = 0; k < 8; k++) begin
         ra = {k[1:0], k[2:0], k[2:0]};
         rb = {k[0], k[2:0], k[2:0], k[2]};
         rc = {k[1:0], k[1:0], k[1:0], k[2:1]};
         check_rails(ra, rb, rc, {2'b11, k[1:0], k[1:0], k[1:0]}, 12'hfff);
         check_rails(ra, rb, rc, {2'b00, k[1:0], k[1:0], k[1:0]}, 12'h000);
      end
      repeat (30) check_rails(8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom),
                              12'($urandom));
      // guardband from pin 6 and from the soft bit
      wr(OFS_PINFUNC, 8'h03);
      i_live <= 4'b1010;
      i_threshold_viol <= 1'b1;
      i_fault_log_req <= 1'b1;
      settle();
      chk("mon_live", 32'ha, {28'h0, o_mon});
      chk("viol_open", 32'h1, {31'h0, viol_acc});
      chk("log_open", 32'h1, {31'h0, log_we});
      i_multi_pin_6 <= 1'b0; // lowered before live values change
      settle();
      chk("guard_pin", 32'h1, {31'h0, guard});
      i_live <= 4'b0101;
      settle();
      chk("mon_held", 32'ha, {28'h0, o_mon});
      chk("viol_gated", 32'h0, {31'h0, viol_acc});
      chk("log_gated", 32'h0, {31'h0, log_we});
      i_multi_pin_6 <= 1'b1;
      settle();
      chk("guard_off", 32'h0, {31'h0, guard});
      chk("mon_follow", 32'h5, {28'h0, o_mon});
      wr(OFS_SWCTL, 8'h02);
      i_live <= 4'b0011;
      settle();
      chk("mon_soft", 32'h5, {28'h0, o_mon});
      wr(OFS_SWCTL, 8'h00);
      i_live <= 4'b0000;
      settle();
      chk("mon_free", 32'h0, {28'h0, o_mon});
      // manual reset with two timeout selections
      for (int s = 0; s < 2; s++) begin
         wr(OFS_TMO, 8'(s << 4));
         i_multi_pin_4 <= 1'b0;
         settle();
         chk("manrst_assert", 32'h1, {31'h0, o_mon.reset_out});
         @(posedge i_clock);
         i_multi_pin_4 <= 1'b1;
         n = 0;
         do begin
            @(posedge i_clock);
            #1;
            n++;
         end while (o_mon.reset_out === 1'b1 && n < 2000);
         chk("manrst_hold_min", 32'h1, {31'h0, n >= TMO_US[s]});
         chk("manrst_hold_max", 32'h1, {31'h0, n <= TMO_US[s] + 3});
      end
      // watchdog pins
      wr(OFS_WD_HI, 8'h03);
      wr(OFS_WD_LO, 8'h70);
      i_wdog_expired <= 1'b1;
      i_multi_pin_6 <= 1'b0;
      settle();
      chk("expiry_pull", 32'h1, {31'h0, p6_oe & ~p6_o});
      chk("expiry_noguard", 32'h0, {31'h0, guard});
      i_wdog_expired <= 1'b0;
      i_multi_pin_6 <= 1'b1;
      settle();
      chk("expiry_release", 32'h0, {31'h0, p6_oe});
      for (int k = 0; k < 6; k++) begin
         i_multi_pin_5 <= 1'($urandom);
         settle();
         chk("kick", {31'h0, i_multi_pin_5}, {31'h0, kick});
      end
      wr(OFS_WD_LO, 8'h00);
      i_multi_pin_5 <= 1'b1;
      settle();
      chk("kick_off", 32'h0, {31'h0, kick});
      end_of_test();
   end
endmodule
